// file: dwq_core.v
// write dma and queued write dma command interpreter with wishbone register file
//
// How it works
// RULE1 - error ends command, address registers hold failing sector; only address low and mid are loaded, address high and drive keep the start
// RULE2 - interface crc error sets error bit 7
// RULE3 - write protected media sets error bit 6
// RULE4 - media change sets bit 5, clears pending state
// RULE5 - missing sector or bad geometry sets bit 4
// RULE6 - change request sets bit 3 until media access
// RULE7 - unsupported, ultra dma or range error abort
// RULE8 - absent media sets error bit 1
// RULE9 - error image: ready, fault, summary, no busy
// RULE10 - host waits ready and sets dma channel
// RULE11 - queued opcode accepted unless packet device
// RULE12 - queued count from features, zero means 256
// RULE13 - tag from count bits 7:3, 0..31
// RULE14 - start address lba or chs by bit 6
// RULE15 - transfer now or after service command
// RULE16 - data image shows tag, release, io low
// RULE17 - data start: ready, request set, busy clear
// RULE18 - bus release image with tag and release
// RULE19 - service flag zero until command ready
// RULE20 - ready released command sets only service flag
// RULE21 - host resumes released command by service command
// RULE22 - no release once data transfer started
// RULE23 - completion: release clear, io and cd set
// RULE24 - image stable except on command or transition
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "dwq_defines.vh"
module dwq_core #(
  parameter INFO_CODE = 8'h5A // arbitrary identification value
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg WB_ERR_O,
  output reg XFER_ACTIVE,
  output reg [8:0] XFER_SECTORS,
  output reg [27:0] XFER_START,
  output reg XFER_LBA
);
  // command phases
  localparam ST_IDLE = 3'd0;
  localparam ST_EXEC = 3'd1;
  localparam ST_RELEASED = 3'd2;
  localparam ST_DATA = 3'd3;
  localparam ST_SERVICE_PENDING_FLAG_WAIT = 3'd4;

  reg [2:0] state;
  reg [7:0] error_report;
  reg [7:0] count_tag_reason;
  reg [7:0] address_low;
  reg [7:0] address_mid;
  reg [7:0] address_high;
  reg [7:0] drive_and_address_top;
  reg [7:0] device_state;
  reg [7:0] transfer_length;
  reg [5:0] config_bits;
  reg queued;
  reg [4:0] tag;
  reg media_change_pending;
  reg media_req;
  reg other_ready;

  // bus decode: one cycle request, ack next edge, drop after
  wire bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  wire wr = bus_req & WB_WE_I & WB_SEL_I[0];
  wire [4:0] tag_field = queued & config_bits[`DWQ_CF_QUEUE] ? tag : 5'h00;

  function known_offset;
    input [7:0] a;
    begin
      case (a)
        `DWQ_OFF_ERROR, `DWQ_OFF_COUNT, `DWQ_OFF_ADDR_LOW, `DWQ_OFF_ADDR_MID,
        `DWQ_OFF_ADDR_HIGH, `DWQ_OFF_DRIVE, `DWQ_OFF_STATE, `DWQ_OFF_LENGTH,
        `DWQ_OFF_OPCODE, `DWQ_OFF_EVENT, `DWQ_OFF_CONFIG, `DWQ_OFF_INFO: known_offset = 1'b1;
        default: known_offset = 1'b0;
      endcase
    end
  endfunction

  // events are write pulses on the event register
  wire ev_wr = wr & (WB_ADR_I == `DWQ_OFF_EVENT) & WB_SEL_I[1];
  wire [15:0] ev = ev_wr ? WB_DAT_I[15:0] : 16'h0000;
  wire op_wr = wr & (WB_ADR_I == `DWQ_OFF_OPCODE);
  wire [7:0] opcode = WB_DAT_I[7:0];
  wire busy = device_state[`DWQ_ST_BUSY];
  // host writes to command block only honoured while not busy
  wire blk_wr = wr & ~busy;

  // error image built from the failure causes
  reg [7:0] next_error;
  always @* begin
    next_error = `DWQ_RST_ZERO;
    next_error[`DWQ_ERR_CRC] = ev[`DWQ_EV_CRC]; // [RULE2]
    next_error[`DWQ_ERR_WP] = config_bits[`DWQ_CF_REMOVABLE] & config_bits[`DWQ_CF_WPROT]; // [RULE3]
    next_error[`DWQ_ERR_MC] = media_change_pending; // [RULE4]
    next_error[`DWQ_ERR_ID_NOT_FOUND] = ev[`DWQ_EV_NOTFOUND] | config_bits[`DWQ_CF_GEOBAD]; // [RULE5]
    next_error[`DWQ_ERR_MCR] = media_req; // [RULE6]
    // range error aborts only when not reported as not found
    next_error[`DWQ_ERR_CMD_ABORTED] = ev[`DWQ_EV_CRC] | ev[`DWQ_EV_UDMA] |
      (ev[`DWQ_EV_RANGE] & ~ev[`DWQ_EV_NOTFOUND]); // [RULE7]
    next_error[`DWQ_ERR_NM] = config_bits[`DWQ_CF_REMOVABLE] & config_bits[`DWQ_CF_NOMEDIA]; // [RULE8]
  end

  wire opcode_ok = (opcode == `DWQ_OP_WRITE_DMA) |
    ((opcode == `DWQ_OP_WRITE_QUEUED) & ~config_bits[`DWQ_CF_PACKET]); // [RULE11]
  // media conditions fail the command at once
  wire media_fail = next_error[`DWQ_ERR_WP] | next_error[`DWQ_ERR_NM] |
    next_error[`DWQ_ERR_ID_NOT_FOUND];

  // main command sequencer and register images
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
      error_report <= `DWQ_RST_ZERO;
      count_tag_reason <= `DWQ_RST_ZERO;
      address_low <= `DWQ_RST_ZERO;
      address_mid <= `DWQ_RST_ZERO;
      address_high <= `DWQ_RST_ZERO;
      drive_and_address_top <= `DWQ_RST_ZERO;
      device_state <= `DWQ_RST_STATE;
      transfer_length <= `DWQ_RST_ZERO;
      config_bits <= 6'h00;
      queued <= 1'b0;
      tag <= 5'h00;
      media_change_pending <= 1'b0;
      media_req <= 1'b0;
      other_ready <= 1'b0;
      XFER_ACTIVE <= 1'b0;
      XFER_SECTORS <= 9'h000;
      XFER_START <= 28'h0000000;
      XFER_LBA <= 1'b0;
    end else begin
      // host loads the command block while busy is clear; image otherwise held [RULE24]
      if (blk_wr && WB_ADR_I == `DWQ_OFF_COUNT) count_tag_reason <= WB_DAT_I[7:0];
      if (blk_wr && WB_ADR_I == `DWQ_OFF_ADDR_LOW) address_low <= WB_DAT_I[7:0];
      if (blk_wr && WB_ADR_I == `DWQ_OFF_ADDR_MID) address_mid <= WB_DAT_I[7:0];
      if (blk_wr && WB_ADR_I == `DWQ_OFF_ADDR_HIGH) address_high <= WB_DAT_I[7:0];
      if (blk_wr && WB_ADR_I == `DWQ_OFF_DRIVE) drive_and_address_top <= WB_DAT_I[7:0];
      if (blk_wr && WB_ADR_I == `DWQ_OFF_LENGTH) transfer_length <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == `DWQ_OFF_CONFIG) config_bits <= WB_DAT_I[5:0];
      if (ev[`DWQ_EV_OTHER]) other_ready <= WB_DAT_I[13];
      // media change state: new change wins over clearing
      if (ev[`DWQ_EV_MCHG]) media_change_pending <= 1'b1;
      else if (op_wr && !busy && opcode_ok) media_change_pending <= 1'b0; // [RULE4]
      // request flag cleared only by status query or media access
      if (ev[`DWQ_EV_MREQ]) media_req <= 1'b1; // [RULE6]
      else if (op_wr && !busy && (opcode_ok || opcode == `DWQ_OP_MEDIA_STATUS)) media_req <= 1'b0;
      case (state)
        ST_IDLE, ST_RELEASED: begin
          if (state == ST_RELEASED && ev[`DWQ_EV_READY]) begin
            device_state[`DWQ_ST_SERVICE_PENDING_FLAG] <= 1'b1; // [RULE20] [RULE19]
            state <= ST_SERVICE_PENDING_FLAG_WAIT;
          end else if (op_wr && !busy) begin
            if (opcode_ok && !(state == ST_RELEASED)) begin
              queued <= opcode == `DWQ_OP_WRITE_QUEUED;
              tag <= count_tag_reason[7:3]; // [RULE13]
              XFER_SECTORS <= (opcode == `DWQ_OP_WRITE_QUEUED ? transfer_length : count_tag_reason)
                == `DWQ_ZERO_COUNT ? `DWQ_FULL_COUNT :
                {1'b0, opcode == `DWQ_OP_WRITE_QUEUED ? transfer_length : count_tag_reason}; // [RULE12]
              XFER_START <= {drive_and_address_top[3:0], address_high, address_mid, address_low};
              XFER_LBA <= drive_and_address_top[`DWQ_DH_LBA]; // [RULE14]
              error_report <= `DWQ_RST_ZERO;
              if (media_fail) begin
                error_report <= next_error;
                device_state <= 8'h41; // [RULE9]
              end else begin
                device_state <= 8'h80 | (device_state & 8'h40);
                state <= ST_EXEC;
              end
            end else begin
              // unsupported command, or any command while released: abort with error image
              error_report <= 8'h04; // [RULE7]
              device_state <= {1'b0, 1'b1, 1'b0, device_state[`DWQ_ST_SERVICE_PENDING_FLAG], 3'b000, 1'b1}; // [RULE9]
            end
          end
        end
        ST_SERVICE_PENDING_FLAG_WAIT: begin
          if (op_wr && opcode == `DWQ_OP_SERVICE) begin // [RULE21]
            device_state <= 8'h48;
            count_tag_reason <= {tag_field, 3'b000};
            XFER_ACTIVE <= 1'b1;
            other_ready <= 1'b0;
            state <= ST_DATA; // [RULE15] [RULE20]
          end
        end
        ST_EXEC: begin
          if (ev[`DWQ_EV_RELEASE] && queued) begin
            count_tag_reason <= {tag_field, 3'b100}; // [RULE18]
            device_state <= {1'b0, 1'b1, 1'b0, other_ready, 4'b0000}; // [RULE18] [RULE19]
            state <= ST_RELEASED;
          end else if (ev[`DWQ_EV_START]) begin
            // data image: tag, release clear, host to device [RULE16]
            if (queued) count_tag_reason <= {tag_field, 3'b000};
            device_state <= {1'b0, 1'b1, 1'b0, queued & other_ready, 1'b1, 3'b000}; // [RULE17]
            XFER_ACTIVE <= 1'b1;
            state <= ST_DATA;
          end else if (ev[`DWQ_EV_FAIL]) begin
            error_report <= next_error;
            device_state <= {2'b01, ev[`DWQ_EV_FAULT], 4'b0000, |next_error}; // [RULE9]
            state <= ST_IDLE;
          end
        end
        ST_DATA: begin
          // release events ignored once data moves [RULE22]
          if (ev[`DWQ_EV_FAIL]) begin
            error_report <= next_error;
            address_low <= WB_DAT_I[23:16]; // failing sector address [RULE1]
            address_mid <= WB_DAT_I[31:24];
            device_state <= {2'b01, ev[`DWQ_EV_FAULT], queued & other_ready, 3'b000,
              |next_error}; // [RULE9]
            if (queued) count_tag_reason <= {tag_field, 3'b011};
            XFER_ACTIVE <= 1'b0;
            state <= ST_IDLE;
          end else if (ev[`DWQ_EV_DONE]) begin
            if (queued) count_tag_reason <= {tag_field, 3'b011}; // [RULE23]
            device_state <= {3'b010, queued & other_ready, 4'b0000};
            XFER_ACTIVE <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // wishbone answer: ack or err one cycle after request
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= bus_req & known_offset(WB_ADR_I);
      WB_ERR_O <= bus_req & ~known_offset(WB_ADR_I);
      WB_DAT_O <= 32'h00000000;
      if (bus_req && !WB_WE_I) begin
        case (WB_ADR_I)
          `DWQ_OFF_ERROR: WB_DAT_O[7:0] <= error_report;
          `DWQ_OFF_COUNT: WB_DAT_O[7:0] <= count_tag_reason;
          `DWQ_OFF_ADDR_LOW: WB_DAT_O[7:0] <= address_low;
          `DWQ_OFF_ADDR_MID: WB_DAT_O[7:0] <= address_mid;
          `DWQ_OFF_ADDR_HIGH: WB_DAT_O[7:0] <= address_high;
          `DWQ_OFF_DRIVE: WB_DAT_O[7:0] <= drive_and_address_top;
          `DWQ_OFF_STATE: WB_DAT_O[7:0] <= device_state;
          `DWQ_OFF_CONFIG: WB_DAT_O[7:0] <= {2'b00, config_bits};
          `DWQ_OFF_INFO: WB_DAT_O[7:0] <= INFO_CODE;
          default: WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // dwq_core

// file: dwq_core_sva.sv
// bus and transfer port assertions for the write command block
`timescale 1ns/1ps
module dwq_core_sva #(
  parameter INFO_CODE = 8'h5A
) (
  input wire SYS_CLK,
  input wire RESET_N,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire WB_ACK_O,
  input wire WB_ERR_O,
  input wire XFER_ACTIVE,
  input wire [8:0] XFER_SECTORS,
  input wire [27:0] XFER_START,
  input wire XFER_LBA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // a request is taken only while no answer stands
  wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  wire rd_st = take && !WB_WE_I && WB_ADR_I == 8'h1C;
  property p_answer; take |-> ##1 (WB_ACK_O ^ WB_ERR_O); endproperty
  a_answer: assert property (p_answer) else $error("request not answered once");
  property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_pulse: assert property (p_pulse) else $error("ack held too long");
  property p_mapped; take && WB_ADR_I inside {8'h1C, 8'h04, 8'h2C} |=> !WB_ERR_O; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped address refused");
  property p_info; take && !WB_WE_I && WB_ADR_I == 8'h30 |=> WB_DAT_O[7:0] == INFO_CODE; endproperty
  a_info: assert property (p_info) else $error("info value wrong");
  property p_ready; rd_st |=> WB_DAT_O[7] || WB_DAT_O[6]; endproperty
  a_ready: assert property (p_ready) else $error("idle without ready");
  property p_drq; rd_st |=> WB_DAT_O[3] == XFER_ACTIVE && !(WB_DAT_O[7] && WB_DAT_O[3]); endproperty
  a_drq: assert property (p_drq) else $error("data request out of step");
  property p_count; XFER_ACTIVE |-> XFER_SECTORS inside {[9'h001:9'h100]}; endproperty
  a_count: assert property (p_count) else $error("sector count out of range");
  property p_hold; XFER_ACTIVE && $past(XFER_ACTIVE) |-> $stable(XFER_START) && $stable(XFER_LBA); endproperty
  a_hold: assert property (p_hold) else $error("transfer address moved");
  c_xfer: cover property ($rose(XFER_ACTIVE));
  c_err: cover property (WB_ERR_O);
  c_service_pending_flag: cover property (rd_st ##1 WB_DAT_O[4]);
endmodule // dwq_core_sva
bind dwq_core dwq_core_sva #(.INFO_CODE(INFO_CODE)) sva_u (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .WB_ERR_O(WB_ERR_O), .XFER_ACTIVE(XFER_ACTIVE), .XFER_SECTORS(XFER_SECTORS),
  .XFER_START(XFER_START), .XFER_LBA(XFER_LBA));

// file: dwq_core_tb_top.sv
// self-checking bench for the write command block
`timescale 1ns/1ps
`include "dwq_defines.vh"
module dwq_core_tb_top;
  reg sys_clk = 1'b0;
  reg reset_n = 1'b0;
  wire cyc, stb, we, ack, err, xact, xlba;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] wdat, rdat;
  wire [8:0] xsec;
  wire [27:0] xstart;
  integer n_mismatch = 0;
  integer checks = 0;
  integer i;
  always #25 sys_clk = ~sys_clk;
  // info value is arbitrary
  dwq_core #(.INFO_CODE(8'h3C)) dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .XFER_ACTIVE(xact),
    .XFER_SECTORS(xsec), .XFER_START(xstart), .XFER_LBA(xlba));
  dwq_host_model host_u (.clk(sys_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_o(wdat), .dat_i(rdat), .ack(ack), .err(err));
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (checks > 0 && n_mismatch == 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] r);
    host_u.bus(w, a, d, q, r);
    if (r == 2'd2) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD bus answer expected ack seen none");
      final_report;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    reg [31:0] q;
    reg [1:0] r;
    acc(1'b1, a, d, q, r);
  endtask
  task rdc(input string what, input [7:0] a, input [7:0] exp);
    reg [31:0] q;
    reg [1:0] r;
    acc(1'b0, a, 32'h0, q, r);
    chk(what, {24'h0, exp}, {24'h0, q[7:0]});
  endtask
  // host checks the ready bit once, then issues the command regardless
  task cmd(input [7:0] op);
    reg [31:0] q;
    reg [1:0] r;
    acc(1'b0, `DWQ_OFF_STATE, 32'h0, q, r);
    chk("ready", 32'h1, {31'h0, q[6]});
    wr(`DWQ_OFF_OPCODE, {24'h0, op});
  endtask
  task t_reset;
    reg [31:0] q;
    reg [1:0] r;
    rdc("reset status", `DWQ_OFF_STATE, 8'h40);
    rdc("info", `DWQ_OFF_INFO, 8'h3C);
    acc(1'b0, 8'h3C, 32'h0, q, r);
    chk("unmapped", 32'h1, {30'h0, r});
  endtask
  task t_queued;
    wr(`DWQ_OFF_CONFIG, 32'h1);
    wr(`DWQ_OFF_COUNT, 32'h68);
    wr(`DWQ_OFF_LENGTH, 32'h0);
    wr(`DWQ_OFF_ADDR_LOW, 32'h11);
    wr(`DWQ_OFF_ADDR_MID, 32'h22);
    wr(`DWQ_OFF_ADDR_HIGH, 32'h33);
    wr(`DWQ_OFF_DRIVE, 32'h45);
    cmd(`DWQ_OP_WRITE_QUEUED);
    rdc("busy", `DWQ_OFF_STATE, 8'hC0);
    wr(`DWQ_OFF_COUNT, 32'hFF);
    wr(`DWQ_OFF_EVENT, 32'h100);
    rdc("release count", `DWQ_OFF_COUNT, 8'h6C);
    rdc("release status", `DWQ_OFF_STATE, 8'h40);
    wr(`DWQ_OFF_EVENT, 32'h80);
    rdc("ready status", `DWQ_OFF_STATE, 8'h50);
    rdc("ready count", `DWQ_OFF_COUNT, 8'h6C);
    cmd(`DWQ_OP_SERVICE);
    rdc("data status", `DWQ_OFF_STATE, 8'h48);
    rdc("data count", `DWQ_OFF_COUNT, 8'h68);
    chk("sectors", 32'h100, {23'h0, xsec});
    chk("start", 32'h05332211, {4'h0, xstart});
    chk("lba", 32'h1, {31'h0, xlba});
    wr(`DWQ_OFF_EVENT, 32'h100);
    rdc("no release", `DWQ_OFF_STATE, 8'h48);
    wr(`DWQ_OFF_EVENT, 32'h1);
    rdc("done status", `DWQ_OFF_STATE, 8'h40);
    rdc("done count", `DWQ_OFF_COUNT, 8'h6B);
  endtask
  task t_dma_fail;
    wr(`DWQ_OFF_CONFIG, 32'h0);
    wr(`DWQ_OFF_COUNT, 32'h0);
    wr(`DWQ_OFF_DRIVE, 32'h0);
    cmd(`DWQ_OP_WRITE_DMA);
    wr(`DWQ_OFF_EVENT, 32'h200);
    rdc("dma data", `DWQ_OFF_STATE, 8'h48);
    chk("chs", 32'h0, {31'h0, xlba});
    // failing sector arrives in the top two bytes
    wr(`DWQ_OFF_EVENT, 32'h775E0006);
    rdc("crc error", `DWQ_OFF_ERROR, 8'h84);
    rdc("fail status", `DWQ_OFF_STATE, 8'h41);
    rdc("fail low", `DWQ_OFF_ADDR_LOW, 8'h5E);
    rdc("fail mid", `DWQ_OFF_ADDR_MID, 8'h77);
    chk("stopped", 32'h0, {31'h0, xact});
  endtask
  task t_abort;
    for (i = 0; i < 2; i = i + 1) begin
      wr(`DWQ_OFF_CONFIG, (i == 0) ? 32'h3 : 32'h0);
      cmd((i == 0) ? `DWQ_OP_WRITE_QUEUED : 8'h00);
      rdc("abort error", `DWQ_OFF_ERROR, 8'h04);
      rdc("abort status", `DWQ_OFF_STATE, 8'h41);
    end
  endtask
  // write protect, no media, bad geometry
  localparam [23:0] MCFG = 24'h0C1420;
  localparam [23:0] MERR = 24'h400210;
  task t_media;
    for (i = 0; i < 3; i = i + 1) begin
      wr(`DWQ_OFF_CONFIG, {24'h0, MCFG[23-8*i -: 8]});
      cmd(`DWQ_OP_WRITE_DMA);
      rdc("media error", `DWQ_OFF_ERROR, MERR[23-8*i -: 8]);
      rdc("media status", `DWQ_OFF_STATE, 8'h41);
    end
  endtask
  // media change and request flags, then fault, ultra dma and range causes
  task t_events;
    wr(`DWQ_OFF_CONFIG, 32'hC);
    wr(`DWQ_OFF_EVENT, 32'h1800);
    cmd(`DWQ_OP_WRITE_DMA);
    rdc("media change", `DWQ_OFF_ERROR, 8'h68);
    cmd(`DWQ_OP_WRITE_DMA);
    rdc("change cleared", `DWQ_OFF_ERROR, 8'h40);
    wr(`DWQ_OFF_EVENT, 32'h1000);
    cmd(`DWQ_OP_MEDIA_STATUS);
    cmd(`DWQ_OP_WRITE_DMA);
    rdc("request cleared", `DWQ_OFF_ERROR, 8'h40);
    wr(`DWQ_OFF_CONFIG, 32'h0);
    cmd(`DWQ_OP_WRITE_DMA);
    wr(`DWQ_OFF_EVENT, 32'h5A);
    rdc("udma error", `DWQ_OFF_ERROR, 8'h04);
    rdc("fault status", `DWQ_OFF_STATE, 8'h61);
    cmd(`DWQ_OP_WRITE_DMA);
    wr(`DWQ_OFF_EVENT, 32'h32);
    rdc("not found", `DWQ_OFF_ERROR, 8'h10);
    rdc("not found status", `DWQ_OFF_STATE, 8'h41);
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_queued;
    t_dma_fail;
    t_abort;
    t_media;
    t_events;
    final_report;
  end
endmodule // dwq_core_tb_top

// file: dwq_defines.vh
// register offsets, bit positions, opcodes and reset values for the write command block
`ifndef DWQ_DEFINES_VH
`define DWQ_DEFINES_VH
// wishbone word offsets (byte addresses)
`define DWQ_OFF_ERROR 8'h04
`define DWQ_OFF_COUNT 8'h08
`define DWQ_OFF_ADDR_LOW 8'h0C
`define DWQ_OFF_ADDR_MID 8'h10
`define DWQ_OFF_ADDR_HIGH 8'h14
`define DWQ_OFF_DRIVE 8'h18
`define DWQ_OFF_STATE 8'h1C
`define DWQ_OFF_LENGTH 8'h20
`define DWQ_OFF_OPCODE 8'h24
`define DWQ_OFF_EVENT 8'h28
`define DWQ_OFF_CONFIG 8'h2C
`define DWQ_OFF_INFO 8'h30
// error register bits
`define DWQ_ERR_CRC 7
`define DWQ_ERR_WP 6
`define DWQ_ERR_MC 5
`define DWQ_ERR_ID_NOT_FOUND 4
`define DWQ_ERR_MCR 3
`define DWQ_ERR_CMD_ABORTED 2
`define DWQ_ERR_NM 1
// status register bits
`define DWQ_ST_BUSY 7
`define DWQ_ST_READY 6
`define DWQ_ST_FAULT 5
`define DWQ_ST_SERVICE_PENDING_FLAG 4
`define DWQ_ST_DRQ 3
`define DWQ_ST_ERR 0
// count register bits in queued images
`define DWQ_CT_REL 2
`define DWQ_CT_IO 1
`define DWQ_CT_CD 0
// head register lba select bit
`define DWQ_DH_LBA 6
// opcodes
`define DWQ_OP_WRITE_DMA 8'hCA
`define DWQ_OP_WRITE_QUEUED 8'hCC
`define DWQ_OP_SERVICE 8'hA2
`define DWQ_OP_MEDIA_STATUS 8'hDA
// reset values and sector count constants
`define DWQ_RST_STATE 8'h40
`define DWQ_RST_ZERO 8'h00
`define DWQ_ZERO_COUNT 8'h00
`define DWQ_FULL_COUNT 9'h100
// event register bits (software models the media and transfer engine)
`define DWQ_EV_DONE 0
`define DWQ_EV_FAIL 1
`define DWQ_EV_CRC 2
`define DWQ_EV_UDMA 3
`define DWQ_EV_RANGE 4
`define DWQ_EV_NOTFOUND 5
`define DWQ_EV_FAULT 6
`define DWQ_EV_READY 7
`define DWQ_EV_RELEASE 8
`define DWQ_EV_START 9
`define DWQ_EV_OTHER 10
`define DWQ_EV_MCHG 11
`define DWQ_EV_MREQ 12
// config register bits
`define DWQ_CF_QUEUE 0
`define DWQ_CF_PACKET 1
`define DWQ_CF_REMOVABLE 2
`define DWQ_CF_WPROT 3
`define DWQ_CF_NOMEDIA 4
`define DWQ_CF_GEOBAD 5
`endif

// file: dwq_host_model.sv
// host adapter model issuing classic wishbone cycles
`timescale 1ns/1ps
module dwq_host_model (
  input wire clk,
  output reg cyc = 1'b0,
  output reg stb = 1'b0,
  output reg we = 1'b0,
  output reg [7:0] adr = 8'h00,
  output reg [3:0] sel = 4'h0,
  output reg [31:0] dat_o = 32'h0,
  input wire [31:0] dat_i,
  input wire ack,
  input wire err
);
  // r: 0 ack, 1 err, 2 no answer within bound
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] q, output [1:0] r);
    integer n;
    n = 0;
    r = 2'd2;
    q = 32'h0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat_o} <= {1'b1, 1'b1, w, a, 4'hF, d};
    while (n < 20 && r == 2'd2) begin
      @(posedge clk);
      n = n + 1;
      if (ack) begin
        r = 2'd0;
        q = dat_i;
      end else if (err) begin
        r = 2'd1;
      end
    end
    // released lines must not keep looking valid
    {cyc, stb, adr, dat_o} <= {1'b0, 1'b0, ~adr, ~dat_o};
  endtask
endmodule // dwq_host_model
